//--- design/ccr_core_regs.v
/*
 * Core register set: arithmetic result, helper, stack top pointer,
 * three-byte data pointer, status word, plus external bus strobes
 * and the multiplexed port zero.
 * Assumes a core sequencer drives the op port and special register
 * accesses synchronously on clock_in; pins arrive asynchronously.
 */
`timescale 1ns/100ps
`include "ccr_defs.vh"

module ccr_core_regs (
	// Clock and reset
	input wire clock_in,
	input wire rstn_in,
	// Core operation port
	input wire [3:0] op_in,
	input wire [7:0] operand_in,
	input wire [23:0] code_addr_in,
	// Special register access
	input wire sfr_wr_in,
	input wire sfr_rd_in,
	input wire [7:0] sfr_addr_in,
	input wire [7:0] sfr_wdata_in,
	output reg [7:0] sfr_rdata_out,
	input wire bit_wr_in,
	input wire [2:0] bit_sel_in,
	input wire bit_val_in,
	// Internal RAM write for stack
	output reg ram_wr_out,
	output reg [7:0] ram_addr_out,
	output reg [7:0] ram_wdata_out,
	// External data access
	input wire data_access_in,
	input wire [7:0] ext_wdata_in,
	input wire ext_write_in,
	output reg [7:0] ext_rdata_out,
	// Pins
	input wire internal_fetch_select_in,
	input wire program_fetch_strobe_pin_in,
	output wire program_fetch_strobe_out,
	output wire addr_latch_strobe_out,
	input wire [7:0] port_zero_in,
	output reg [7:0] port_zero_out,
	output reg [7:0] port_zero_oe_out,
	input wire port_zero_wr_in,
	input wire [7:0] port_zero_latch_in,
	// Status
	output wire [7:0] core_status_word_out,
	output wire [1:0] bank_out,
	output wire ext_fetch_out,
	output reg download_mode_out
);

	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] arith_result_reg;
	reg [7:0] helper_reg;
	reg [7:0] stack_top_pointer;
	reg [7:0] pointer_page_byte;
	reg [7:0] pointer_high_byte;
	reg [7:0] pointer_low_byte;
	reg [7:0] core_status_word;
	reg [7:0] port_zero_latch;
	reg [2:0] sel_sync;
	reg [2:0] fetch_pin_sync;
	reg [7:0] p0_s1;
	reg [7:0] p0_s2;
	reg [7:0] p0_s3;
	reg sel_level;
	reg strap_done;
	reg [1:0] strap_wait;
	wire ext_fetch;
	wire phase_end;
	wire [15:0] data_pointer_word;
	wire [16:0] ptr_inc;
	reg [7:0] next_arith;
	reg [7:0] next_helper;
	reg next_carry;
	reg next_half;
	reg next_signed;
	reg [8:0] sum9;
	reg [4:0] sum5;
	reg [15:0] prod;

	assign data_pointer_word = {pointer_high_byte, pointer_low_byte};
	assign ptr_inc = {1'b0, data_pointer_word} + 17'd1;
	assign core_status_word_out = core_status_word;
	assign bank_out = {core_status_word[`CCR_BIT_BANK_HI], core_status_word[`CCR_BIT_BANK_LO]};
	// Internal fetch only when selected high and inside low 8K
	assign ext_fetch = !sel_level || (code_addr_in > `CCR_INT_CODE_TOP);
	assign ext_fetch_out = ext_fetch;

	// ****************************************
	// Strobe generator
	// ****************************************
	ccr_strobe_gen ccr_strobe_gen_inst (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.ext_fetch_in(ext_fetch),
		.data_access_in(data_access_in),
		.addr_latch_strobe_out(addr_latch_strobe_out),
		.program_fetch_strobe_n_out(program_fetch_strobe_out),
		.phase_end_out(phase_end)
	);

	// ****************************************
	// Pin synchronisers and reset strap
	// ****************************************
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sel_sync <= 3'b000;
			fetch_pin_sync <= 3'b111;
			p0_s1 <= 8'h00;
			p0_s2 <= 8'h00;
			p0_s3 <= 8'h00;
			sel_level <= 1'b0;
			strap_done <= 1'b0;
			strap_wait <= 2'h0;
			download_mode_out <= 1'b0;
		end else begin
			sel_sync <= {sel_sync[1:0], internal_fetch_select_in};
			fetch_pin_sync <= {fetch_pin_sync[1:0], program_fetch_strobe_pin_in};
			p0_s1 <= port_zero_in;
			p0_s2 <= p0_s1;
			p0_s3 <= p0_s2;
			if (sel_sync[1] == sel_sync[2])
				sel_level <= sel_sync[2];
			// Strap sampled once, after synchroniser fills following release;
			// the reset fill of the chain must not count as a pin level
			if (strap_wait != `CCR_STRAP_WAIT)
				strap_wait <= strap_wait + 2'h1;
			else if (!strap_done && fetch_pin_sync[1] == fetch_pin_sync[2]) begin
				strap_done <= 1'b1;
				download_mode_out <= !fetch_pin_sync[2];
			end
		end
	end

	// ****************************************
	// Arithmetic next values
	// ****************************************
	always @* begin
		next_arith = arith_result_reg;
		next_helper = helper_reg;
		next_carry = core_status_word[`CCR_BIT_CARRY];
		next_half = core_status_word[`CCR_BIT_HALF];
		next_signed = core_status_word[`CCR_BIT_SIGNED];
		sum9 = 9'h000;
		sum5 = 5'h00;
		prod = 16'h0000;
		case (op_in)
			`CCR_OP_ADD: begin
				sum9 = {1'b0, arith_result_reg} + {1'b0, operand_in};
				sum5 = {1'b0, arith_result_reg[3:0]} + {1'b0, operand_in[3:0]};
				next_arith = sum9[7:0];
				next_carry = sum9[8];
				next_half = sum5[4];
				next_signed = (arith_result_reg[7] == operand_in[7]) && (sum9[7] != operand_in[7]);
			end
			`CCR_OP_SUB: begin
				sum9 = {1'b0, arith_result_reg} - {1'b0, operand_in};
				sum5 = {1'b0, arith_result_reg[3:0]} - {1'b0, operand_in[3:0]};
				next_arith = sum9[7:0];
				next_carry = sum9[8];
				next_half = sum5[4];
				next_signed = (arith_result_reg[7] != operand_in[7]) && (sum9[7] != arith_result_reg[7]);
			end
			`CCR_OP_MUL: begin
				prod = arith_result_reg * helper_reg;
				next_arith = prod[7:0];
				next_helper = prod[15:8];
				next_carry = 1'b0;
				next_signed = (prod[15:8] != 8'h00);
			end
			`CCR_OP_DIV: begin
				next_carry = 1'b0;
				if (helper_reg == 8'h00) begin
					next_signed = 1'b1;
				end else begin
					next_arith = arith_result_reg / helper_reg;
					next_helper = arith_result_reg % helper_reg;
					next_signed = 1'b0;
				end
			end
			`CCR_OP_AND: next_arith = arith_result_reg & operand_in;
			`CCR_OP_OR: next_arith = arith_result_reg | operand_in;
			`CCR_OP_XOR: next_arith = arith_result_reg ^ operand_in;
			default: next_arith = arith_result_reg;
		endcase
		if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_ARITH)
			next_arith = sfr_wdata_in;
		if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_HELPER)
			next_helper = sfr_wdata_in;
	end

	// ****************************************
	// Register updates
	// ****************************************
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arith_result_reg <= `CCR_RST_ZERO;
			helper_reg <= `CCR_RST_ZERO;
			stack_top_pointer <= `CCR_RST_STACK;
			pointer_page_byte <= `CCR_RST_ZERO;
			pointer_high_byte <= `CCR_RST_ZERO;
			pointer_low_byte <= `CCR_RST_ZERO;
			core_status_word <= `CCR_RST_STATUS;
			ram_wr_out <= 1'b0;
			ram_addr_out <= 8'h00;
			ram_wdata_out <= 8'h00;
		end else begin
			arith_result_reg <= next_arith;
			helper_reg <= next_helper;
			ram_wr_out <= 1'b0;
			if (op_in == `CCR_OP_PUSH) begin
				// Pointer advances first, the byte lands at the new top
				stack_top_pointer <= stack_top_pointer + 8'h01;
				ram_wr_out <= 1'b1;
				ram_addr_out <= stack_top_pointer + 8'h01;
				ram_wdata_out <= operand_in;
			end else if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_STACK) begin
				stack_top_pointer <= sfr_wdata_in;
			end
			if (op_in == `CCR_OP_PTR_INC) begin
				pointer_low_byte <= ptr_inc[7:0];
				pointer_high_byte <= ptr_inc[15:8];
				pointer_page_byte <= pointer_page_byte + {7'h00, ptr_inc[16]};
			end else begin
				if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_PTR_LOW)
					pointer_low_byte <= sfr_wdata_in;
				if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_PTR_HIGH)
					pointer_high_byte <= sfr_wdata_in;
				if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_PTR_PAGE)
					pointer_page_byte <= sfr_wdata_in;
			end
			// Flag updates first, then software writes, parity last
			core_status_word[`CCR_BIT_CARRY] <= next_carry;
			core_status_word[`CCR_BIT_HALF] <= next_half;
			core_status_word[`CCR_BIT_SIGNED] <= next_signed;
			if (sfr_wr_in && sfr_addr_in == `CCR_ADDR_STATUS)
				core_status_word[7:1] <= sfr_wdata_in[7:1];
			else if (bit_wr_in && bit_sel_in != `CCR_BIT_PARITY)
				core_status_word[bit_sel_in] <= bit_val_in;
			core_status_word[`CCR_BIT_PARITY] <= ^next_arith;
		end
	end

	// ****************************************
	// Special register read
	// ****************************************
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sfr_rdata_out <= 8'h00;
		end else if (sfr_rd_in) begin
			case (sfr_addr_in)
				`CCR_ADDR_STATUS: sfr_rdata_out <= core_status_word;
				`CCR_ADDR_ARITH: sfr_rdata_out <= arith_result_reg;
				`CCR_ADDR_HELPER: sfr_rdata_out <= helper_reg;
				`CCR_ADDR_STACK: sfr_rdata_out <= stack_top_pointer;
				`CCR_ADDR_PTR_LOW: sfr_rdata_out <= pointer_low_byte;
				`CCR_ADDR_PTR_HIGH: sfr_rdata_out <= pointer_high_byte;
				`CCR_ADDR_PTR_PAGE: sfr_rdata_out <= pointer_page_byte;
				default: sfr_rdata_out <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Port zero
	// ****************************************
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_zero_latch <= 8'hff;
			port_zero_out <= 8'h00;
			port_zero_oe_out <= 8'h00;
			ext_rdata_out <= 8'h00;
		end else begin
			if (port_zero_wr_in)
				port_zero_latch <= port_zero_latch_in;
			if (data_access_in || ext_fetch) begin
				// Bus role: drive both levels actively, float all bits during a data read
				port_zero_oe_out <= (data_access_in && !ext_write_in) ? 8'h00 : 8'hff;
				port_zero_out <= (phase_end || !data_access_in) ? pointer_low_byte : ext_wdata_in;
			end else begin
				// Open drain: only zeros are driven, ones float
				port_zero_oe_out <= ~port_zero_latch;
				port_zero_out <= 8'h00;
			end
			if (p0_s2 == p0_s3)
				ext_rdata_out <= p0_s3;
		end
	end

endmodule

//--- inc/ccr_defs.vh
/*
 * Constants for the core register set and external memory strobes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// ****************************************
// Special register addresses
// ****************************************
`define CCR_ADDR_STATUS 8'hd0
`define CCR_ADDR_ARITH 8'he0
`define CCR_ADDR_HELPER 8'hf0
`define CCR_ADDR_STACK 8'h81
`define CCR_ADDR_PTR_LOW 8'h82
`define CCR_ADDR_PTR_HIGH 8'h83
`define CCR_ADDR_PTR_PAGE 8'h84

// ****************************************
// Reset values
// ****************************************
`define CCR_RST_STATUS 8'h00
`define CCR_RST_STACK 8'h07
`define CCR_RST_ZERO 8'h00

// ****************************************
// Status word bit positions
// ****************************************
`define CCR_BIT_CARRY 7
`define CCR_BIT_HALF 6
`define CCR_BIT_USER_A 5
`define CCR_BIT_BANK_HI 4
`define CCR_BIT_BANK_LO 3
`define CCR_BIT_SIGNED 2
`define CCR_BIT_USER_B 1
`define CCR_BIT_PARITY 0

// ****************************************
// Operation codes on the core command port
// ****************************************
`define CCR_OP_NONE 4'h0
`define CCR_OP_ADD 4'h1
`define CCR_OP_SUB 4'h2
`define CCR_OP_MUL 4'h3
`define CCR_OP_DIV 4'h4
`define CCR_OP_AND 4'h5
`define CCR_OP_OR 4'h6
`define CCR_OP_XOR 4'h7
`define CCR_OP_PUSH 4'h8
`define CCR_OP_PTR_INC 4'h9

// ****************************************
// Timing: machine phase of six oscillator periods
// ****************************************
`define CCR_PHASE_LEN 3'd6
`define CCR_PHASE_LAST 3'd5
`define CCR_STROBE_LOW 3'd2
`define CCR_INT_CODE_TOP 24'h001fff
`define CCR_STRAP_WAIT 2'h3

`endif

//--- design/ccr_strobe_gen.v
/*
 * Six-period machine phase generator for fetch and latch strobes.
 * Assumes one oscillator period per clock_in cycle.
 */
`timescale 1ns/100ps
`include "ccr_defs.vh"

module ccr_strobe_gen (
	// Clock and reset
	input wire clock_in,
	input wire rstn_in,
	// Control
	input wire ext_fetch_in,
	input wire data_access_in,
	// Strobes
	output reg addr_latch_strobe_out,
	output reg program_fetch_strobe_n_out,
	output wire phase_end_out
);

	reg [2:0] phase;

	assign phase_end_out = (phase == `CCR_PHASE_LAST);

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase <= 3'd0;
			addr_latch_strobe_out <= 1'b0;
			program_fetch_strobe_n_out <= 1'b1;
		end else begin
			if (phase == `CCR_PHASE_LAST)
				phase <= 3'd0;
			else
				phase <= phase + 3'd1;
			// One latch pulse per phase unless a data access owns the bus
			addr_latch_strobe_out <= (phase == `CCR_PHASE_LAST) && !data_access_in;
			// Fetch strobe low in later part of phase, only for external code
			program_fetch_strobe_n_out <= !(ext_fetch_in && !data_access_in &&
				(phase >= `CCR_STROBE_LOW) && (phase != `CCR_PHASE_LAST));
		end
	end

endmodule

//--- test/ccr_core_regs_assertions.sv
/* Port checker for ccr_core_regs.
   Assumes one clock, async active-low reset. */
`timescale 1ns/100ps
module ccr_chk (
	// Clock, reset and inputs
	input wire clock_in,
	input wire rstn_in,
	input wire [3:0] op_in,
	input wire [7:0] operand_in,
	input wire data_access_in,
	input wire ext_write_in,
	input wire [7:0] ext_wdata_in,
	// Outputs
	input wire ram_wr_out,
	input wire [7:0] ram_addr_out,
	input wire [7:0] ram_wdata_out,
	input wire program_fetch_strobe_out,
	input wire addr_latch_strobe_out,
	input wire ext_fetch_out,
	input wire [7:0] port_zero_out,
	input wire [7:0] port_zero_oe_out,
	input wire [7:0] core_status_word_out,
	input wire [1:0] bank_out
);
	// Reference machine phase, 0 to 5 from reset; slot 5 carries the address
	reg [2:0] phase_ref;
	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			phase_ref <= 3'h0;
		else if (phase_ref == 3'h5)
			phase_ref <= 3'h0;
		else
			phase_ref <= phase_ref + 3'h1;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	a_push_data: assert property (op_in == 4'h8 |=> ram_wr_out && ram_wdata_out == $past(operand_in))
		else $error("push write wrong");
	a_push_step: assert property (ram_wr_out && $past(ram_wr_out) |-> ram_addr_out == $past(ram_addr_out) + 8'h01)
		else $error("push address step wrong");
	a_latch_spacing: assert property (addr_latch_strobe_out |=> !addr_latch_strobe_out [*5])
		else $error("latch strobe too often");
	a_latch_quiet: assert property (data_access_in ##1 data_access_in |-> !addr_latch_strobe_out)
		else $error("latch strobe in data access");
	a_fetch_gate: assert property (!program_fetch_strobe_out |-> $past(ext_fetch_out) && !$past(data_access_in))
		else $error("fetch strobe low wrongly");
	a_bank_select: assert property (bank_out == core_status_word_out[4:3])
		else $error("bank select wrong");
	a_read_float: assert property (data_access_in && !ext_write_in |=> port_zero_oe_out == 8'h00)
		else $error("port driven in read");
	a_write_drive: assert property (data_access_in && ext_write_in && phase_ref != 3'h5 |=>
		port_zero_oe_out == 8'hff && port_zero_out == $past(ext_wdata_in)) else $error("port write wrong");
	a_status_reset: assert property ($rose(rstn_in) |-> core_status_word_out == 8'h00)
		else $error("status reset wrong");
	cover property (op_in == 4'h8);
	cover property (data_access_in && ext_write_in);
	cover property ($fell(program_fetch_strobe_out));
endmodule
bind ccr_core_regs ccr_chk ccr_chk_inst (.clock_in(clock_in), .rstn_in(rstn_in), .op_in(op_in),
	.operand_in(operand_in), .data_access_in(data_access_in), .ext_write_in(ext_write_in),
	.ext_wdata_in(ext_wdata_in), .ram_wr_out(ram_wr_out), .ram_addr_out(ram_addr_out),
	.ram_wdata_out(ram_wdata_out), .program_fetch_strobe_out(program_fetch_strobe_out),
	.addr_latch_strobe_out(addr_latch_strobe_out), .ext_fetch_out(ext_fetch_out), .port_zero_out(port_zero_out),
	.port_zero_oe_out(port_zero_oe_out), .core_status_word_out(core_status_word_out), .bank_out(bank_out));

//--- test/ccr_ext_mem.sv
/* External memory on the multiplexed port zero.
   Resolves the wire level and feeds it back to the block. */
`timescale 1ns/100ps
module ccr_ext_mem (
	input wire clock_in,
	input wire ale_in,
	input wire program_fetch_strobe_n_in,
	input wire rd_in,
	input wire [7:0] p0_in,
	input wire [7:0] p0_oe_in,
	output wire [7:0] p0_wire_out
);
	reg [7:0] addr_lo = 8'h00;
	reg [7:0] last = 8'h00;
	wire drive = !program_fetch_strobe_n_in || rd_in;
	// Floating bits show addr_lo ^ 8'h5a while a fetch strobe or read drives, else the inverse of the last level
	assign p0_wire_out = (p0_oe_in & p0_in) | (~p0_oe_in & (drive ? addr_lo ^ 8'h5a : ~last));
	always @(posedge clock_in) begin
		if (ale_in) begin
			addr_lo <= p0_wire_out;
		end
		last <= p0_wire_out;
	end
endmodule

//--- test/ccr_core_regs_tb.sv
/* Self-checking bench for ccr_core_regs.
   Uses ccr_ext_mem on port zero and the bound checker. */
`timescale 1ns/100ps
module ccr_core_regs_tb;
	reg clock_in = 0, rstn_in = 0, swr = 0, srd = 0, bwr = 0, bval = 0, dacc = 0, ewr = 0, sel = 1, pwr = 0, fpin = 1;
	reg [3:0] op = 0;
	reg [2:0] bsel = 0;
	reg [7:0] opnd = 0, sa = 0, sd = 0, ewd = 0, plat = 8'hff;
	reg [23:0] caddr = 24'h000100;
	wire [7:0] rd, ram_a, ram_d, erd, p0, p0o, p0oe, stat;
	wire [1:0] bank;
	wire ram_wr, program_fetch_strobe, ale, extf, dl;
	integer num_errors = 0, comparisons = 0, cycles = 0, na, np;
	ccr_core_regs ccr_core_regs_inst (.clock_in(clock_in), .rstn_in(rstn_in), .op_in(op), .operand_in(opnd),
		.code_addr_in(caddr), .sfr_wr_in(swr), .sfr_rd_in(srd), .sfr_addr_in(sa), .sfr_wdata_in(sd),
		.sfr_rdata_out(rd), .bit_wr_in(bwr), .bit_sel_in(bsel), .bit_val_in(bval), .ram_wr_out(ram_wr),
		.ram_addr_out(ram_a), .ram_wdata_out(ram_d), .data_access_in(dacc), .ext_wdata_in(ewd),
		.ext_write_in(ewr), .ext_rdata_out(erd), .internal_fetch_select_in(sel), .program_fetch_strobe_pin_in(fpin),
		.program_fetch_strobe_out(program_fetch_strobe), .addr_latch_strobe_out(ale), .port_zero_in(p0), .port_zero_out(p0o),
		.port_zero_oe_out(p0oe), .port_zero_wr_in(pwr), .port_zero_latch_in(plat), .core_status_word_out(stat),
		.bank_out(bank), .ext_fetch_out(extf), .download_mode_out(dl));
	ccr_ext_mem ccr_ext_mem_inst (.clock_in(clock_in), .ale_in(ale), .program_fetch_strobe_n_in(program_fetch_strobe), .rd_in(dacc && !ewr),
		.p0_in(p0o), .p0_oe_in(p0oe), .p0_wire_out(p0));
	// ****************************************
	// Clock, timeout and verdict
	// ****************************************
	initial begin
		forever #20 clock_in = !clock_in;
	end
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end
	task print_verdict;
		begin
			if (num_errors == 0 && comparisons > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	// ****************************************
	// Bus tasks
	// ****************************************
	task chk(input [7:0] got, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task sw(input [7:0] a, input [7:0] d);
		begin
			@(negedge clock_in); swr = 1; sa = a; sd = d;
			@(negedge clock_in); swr = 0;
		end
	endtask
	task sr(input [7:0] a, input [7:0] exp);
		begin
			@(negedge clock_in); srd = 1; sa = a;
			@(negedge clock_in); srd = 0;
			chk(rd, exp);
		end
	endtask
	task do_op(input [3:0] o, input [7:0] d);
		begin
			@(negedge clock_in); op = o; opnd = d;
			@(negedge clock_in); op = 0;
		end
	endtask
	task count;
		begin
			na = 0; np = 0;
			repeat (2) @(negedge clock_in);
			repeat (12) begin
				@(negedge clock_in); na = na + ale; np = np + !program_fetch_strobe;
			end
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		begin
			sr(8'h81, 8'h07);
			sr(8'hd0, 8'h00);
			sr(8'h55, 8'h00);
			chk({7'h00, dl}, 8'h00);
		end
	endtask
	task t_push;
		begin
			// Two pushes back to back
			@(negedge clock_in); op = 4'h8; opnd = 8'h3c;
			@(negedge clock_in); opnd = 8'hc3;
			chk({ram_wr, ram_a[6:0]}, 8'h88);
			chk(ram_d, 8'h3c);
			@(negedge clock_in); op = 4'h0;
			chk(ram_a, 8'h09);
			chk(ram_d, 8'hc3);
			sr(8'h81, 8'h09);
		end
	endtask
	task t_arith;
		begin
			sw(8'he0, 8'h0f); do_op(4'h1, 8'h01);
			sr(8'he0, 8'h10);
			chk({7'h00, stat[0]}, 8'h01);
			chk(stat & 8'hc4, 8'h40);
			sw(8'he0, 8'h10); sw(8'hf0, 8'h20); do_op(4'h3, 8'h00);
			sr(8'he0, 8'h00);
			sr(8'hf0, 8'h02);
			sw(8'he0, 8'h25); sw(8'hf0, 8'h07); do_op(4'h4, 8'h00);
			sr(8'he0, 8'h05);
			sr(8'hf0, 8'h02);
			do_op(4'h5, 8'h0c); do_op(4'h6, 8'h30); do_op(4'h7, 8'hff);
			sr(8'he0, 8'hcb);
			sw(8'hf0, 8'ha5);
			sr(8'hf0, 8'ha5);
		end
	endtask
	task t_ptr;
		begin
			sw(8'h82, 8'hff); sw(8'h83, 8'hff); sw(8'h84, 8'h01); do_op(4'h9, 8'h00);
			sr(8'h84, 8'h02);
			sr(8'h83, 8'h00);
			sr(8'h82, 8'h00);
		end
	endtask
	task t_status;
		begin
			sw(8'hd0, 8'h18);
			sr(8'hd0, 8'h19);
			@(negedge clock_in); bwr = 1; bsel = 3'd4;
			@(negedge clock_in); bwr = 0;
			chk({6'h00, bank}, 8'h01);
		end
	endtask
	task t_strobe;
		begin
			count;
			chk(na, 8'h02);
			chk(np, 8'h00);
			chk({7'h00, extf}, 8'h00);
			sel = 0; repeat (6) @(negedge clock_in);
			count;
			chk(np, 8'h06);
			chk(na, 8'h02);
			dacc = 1; count;
			chk(np + na, 8'h00);
			chk(p0oe, 8'h00);
			chk(erd, p0);
			dacc = 0; sel = 1; caddr = 24'h002000; repeat (6) @(negedge clock_in);
			chk({7'h00, extf}, 8'h01);
			caddr = 24'h000100;
		end
	endtask
	task t_port;
		begin
			@(negedge clock_in); pwr = 1; plat = 8'h0f;
			@(negedge clock_in); pwr = 0; @(negedge clock_in);
			chk(p0oe, 8'hf0);
			// Start the write right after a latch pulse so no address slot falls before the check
			@(negedge clock_in);
			while (!ale) @(negedge clock_in);
			dacc = 1; ewr = 1; ewd = 8'ha5;
			repeat (2) @(negedge clock_in);
			chk(p0oe, 8'hff);
			chk(p0, 8'ha5);
			dacc = 0; ewr = 0;
		end
	endtask
	task t_strap;
		begin
			@(negedge clock_in); fpin = 0; rstn_in = 0;
			repeat (2) @(negedge clock_in);
			rstn_in = 1;
			repeat (6) @(negedge clock_in);
			chk({7'h00, dl}, 8'h01);
			fpin = 1;
			sr(8'h81, 8'h07);
			sr(8'hd0, 8'h00);
		end
	endtask
	initial begin
		repeat (6) @(negedge clock_in);
		rstn_in = 1;
		t_reset; t_push; t_arith; t_ptr; t_status; t_strobe; t_port; t_strap;
		print_verdict;
	end
endmodule
